// [logic/pss_status_summary.v]
// Purpose: Status summary of a power module, read over the serial management bus.
// Assumes: Bus clock and data come from pins and are oversampled by clock_i.
// Notes: Detailed flag latching lives here; summaries are pure logic.
`timescale 1ns/1ps
`default_nettype none
`include "pss_consts.vh"
module pss_status_summary #(
    parameter [6:0] DEV_ADDR = `PSS_ADDR_RESET
) (
    input wire clock_i,
    input wire rst_b_i,
    input wire scl_i,
    input wire sda_i,
    output wire sda_o,
    output wire sda_oe_o,
    input wire [7:0] vout_event_i,
    input wire [7:0] iout_event_i,
    input wire [7:0] temp_event_i,
    input wire [7:0] cml_event_i,
    input wire [7:0] mfr_event_i,
    input wire vin_above_on_i,
    input wire vin_below_off_i,
    input wire converter_en_i,
    input wire loop_slave_i,
    input wire power_not_good_i,
    input wire [7:0] nv_mask_vout_i,
    input wire [7:0] nv_mask_iout_i,
    input wire [7:0] nv_mask_input_i,
    input wire [7:0] nv_mask_temp_i,
    input wire [7:0] nv_mask_cml_i,
    input wire [7:0] nv_mask_mfr_i,
    output wire smbalert_b_o
);
    localparam ST_IDLE = 6'b000001;
    localparam ST_ADDR = 6'b000010;
    localparam ST_ACK = 6'b000100;
    localparam ST_RX = 6'b001000;
    localparam ST_TX = 6'b010000;
    localparam ST_TXACK = 6'b100000;

    wire scl_s;
    wire sda_s;
    wire [1:0] pin_reset = 2'b11;
    pss_sync2 #(.WIDTH(2)) u_sync (
        .clock_i(clock_i),
        .rst_b_i(rst_b_i),
        .async_i({scl_i, sda_i}),
        .reset_val_i(pin_reset),
        .sync_o({scl_s, sda_s})
    );

    reg scl_d_ff;
    reg sda_d_ff;
    always @(posedge clock_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            scl_d_ff <= 1'b1;
            sda_d_ff <= 1'b1;
        end else begin
            scl_d_ff <= scl_s;
            sda_d_ff <= sda_s;
        end
    end
    wire scl_rise = scl_s & ~scl_d_ff;
    wire scl_fall = ~scl_s & scl_d_ff;
    wire start_c = scl_s & scl_d_ff & sda_d_ff & ~sda_s;
    wire stop_c = scl_s & scl_d_ff & ~sda_d_ff & sda_s;

    // Detailed source flags: set by hardware events, cleared by host writes.
    reg [7:0] vout_ff;
    reg [7:0] iout_ff;
    reg [7:0] input_ff;
    reg [7:0] temp_ff;
    reg [7:0] cml_ff;
    reg [7:0] mfr_ff;
    reg vin_seen_ff;
    reg pgood_seen_ff;
    reg png_mask_ff;
    reg [7:0] clr_vout;
    reg [7:0] clr_iout;
    reg [7:0] clr_input;
    reg [7:0] clr_temp;
    reg [7:0] clr_cml;
    reg [7:0] clr_mfr;
    reg png_mask_wr;
    reg png_mask_val;

    // Set wins over clear so an event in the clearing cycle is kept.
    function [7:0] upd;
        input [7:0] cur;
        input [7:0] set;
        input [7:0] clr;
        begin
            upd = (cur & ~clr) | set;
        end
    endfunction

    wire lowvin_set = vin_seen_ff & vin_below_off_i;
    always @(posedge clock_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            vout_ff <= 8'h00;
            iout_ff <= 8'h00;
            input_ff <= `PSS_INPUT_RESET;
            temp_ff <= 8'h00;
            cml_ff <= 8'h00;
            mfr_ff <= 8'h00;
            vin_seen_ff <= 1'b0;
            pgood_seen_ff <= 1'b0;
            png_mask_ff <= `PSS_PNG_MASK_RESET;
        end else begin
            vout_ff <= upd(vout_ff, vout_event_i & 8'hFC, clr_vout);
            iout_ff <= upd(iout_ff, iout_event_i & 8'hA0, clr_iout);
            temp_ff <= upd(temp_ff, temp_event_i & 8'hC0, clr_temp);
            cml_ff <= upd(cml_ff, cml_event_i, clr_cml);
            mfr_ff <= upd(mfr_ff, mfr_event_i & 8'hC0, clr_mfr);
            if (!vin_seen_ff) begin
                input_ff[`PSS_INPUT_LOWVIN] <= ~vin_above_on_i;
            end else begin
                input_ff[`PSS_INPUT_LOWVIN] <= lowvin_set |
                    (input_ff[`PSS_INPUT_LOWVIN] & ~clr_input[`PSS_INPUT_LOWVIN]);
            end
            if (vin_above_on_i) begin
                vin_seen_ff <= 1'b1;
            end
            if (!power_not_good_i) begin
                pgood_seen_ff <= 1'b1;
            end
            if (png_mask_wr) begin
                png_mask_ff <= png_mask_val;
            end
        end
    end

    wire [7:0] sum_byte;
    wire [7:0] sum_high;
    pss_summary u_sum (
        .vout_status_i(vout_ff),
        .iout_status_i(iout_ff),
        .input_status_i(input_ff),
        .temp_status_i(temp_ff),
        .cml_status_i(cml_ff),
        .mfr_status_i(mfr_ff),
        .converter_en_i(converter_en_i),
        .loop_slave_i(loop_slave_i),
        .power_not_good_i(power_not_good_i),
        .summary_byte_o(sum_byte),
        .summary_high_o(sum_high)
    );

    wire alert_src = |(vout_ff & ~nv_mask_vout_i & {8{~loop_slave_i}}) |
        |(iout_ff & ~nv_mask_iout_i) |
        |(input_ff & ~nv_mask_input_i & {8{vin_seen_ff}}) |
        |(temp_ff & ~nv_mask_temp_i) | |(cml_ff & ~nv_mask_cml_i) |
        |(mfr_ff & ~nv_mask_mfr_i);
    wire alert_png = power_not_good_i & ~png_mask_ff & pgood_seen_ff;
    reg alert_ff;
    always @(posedge clock_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            alert_ff <= 1'b0;
        end else begin
            alert_ff <= alert_src | alert_png;
        end
    end
    assign smbalert_b_o = ~alert_ff;

    // Serial slave: address, command, then either data writes or a read.
    reg [5:0] state_ff;
    reg [5:0] nxt_state;
    reg [3:0] bit_cnt_ff;
    reg [7:0] shift_ff;
    reg [7:0] cmd_ff;
    reg [1:0] byte_idx_ff;
    reg rd_ff;
    reg drive_ff;
    reg [7:0] tx_ff;
    reg nack_ff;
    always @* begin
        nxt_state = state_ff;
        case (state_ff)
            ST_IDLE: nxt_state = ST_IDLE;
            ST_ADDR: if (scl_fall && bit_cnt_ff == 4'h8) begin
                nxt_state = (shift_ff[7:1] == DEV_ADDR) ? ST_ACK : ST_IDLE;
            end
            ST_ACK: if (scl_fall) begin
                nxt_state = rd_ff ? ST_TX : ST_RX;
            end
            ST_RX: if (scl_fall && bit_cnt_ff == 4'h8) begin
                nxt_state = ST_ACK;
            end
            ST_TX: if (scl_fall && bit_cnt_ff == 4'h8) begin
                nxt_state = ST_TXACK;
            end
            ST_TXACK: if (scl_fall) begin
                nxt_state = nack_ff ? ST_IDLE : ST_TX;
            end
            default: nxt_state = ST_IDLE;
        endcase
        if (start_c) begin
            nxt_state = ST_ADDR;
        end else if (stop_c) begin
            nxt_state = ST_IDLE;
        end
    end

    function [7:0] read_mux;
        input [7:0] cmd;
        input [1:0] idx;
        input [7:0] lo;
        input [7:0] hi;
        begin
            if (cmd == `PSS_CMD_SUMMARY_BYTE) begin
                read_mux = lo;
            end else if (cmd == `PSS_CMD_SUMMARY_WORD) begin
                read_mux = (idx == 2'h0) ? lo : hi;
            end else begin
                read_mux = 8'h00;
            end
        end
    endfunction

    wire [7:0] rx_byte = {shift_ff[6:0], sda_s};
    always @* begin
        clr_vout = 8'h00;
        clr_iout = 8'h00;
        clr_input = 8'h00;
        clr_temp = 8'h00;
        clr_cml = 8'h00;
        clr_mfr = 8'h00;
        png_mask_wr = 1'b0;
        png_mask_val = rx_byte[`PSS_HB_PNG];
        if (state_ff == ST_RX && scl_rise && bit_cnt_ff == 4'h7 && byte_idx_ff != 2'h0) begin
            case (cmd_ff)
                `PSS_CMD_STATUS_VOUT: clr_vout = rx_byte;
                `PSS_CMD_STATUS_IOUT: clr_iout = rx_byte;
                `PSS_CMD_STATUS_INPUT: clr_input = rx_byte;
                `PSS_CMD_STATUS_TEMP: clr_temp = rx_byte;
                `PSS_CMD_STATUS_CML: clr_cml = rx_byte;
                `PSS_CMD_STATUS_MFR: clr_mfr = rx_byte;
                `PSS_CMD_MASK_WR: png_mask_wr = 1'b1;
                default: clr_vout = 8'h00;
            endcase
        end
    end

    always @(posedge clock_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            state_ff <= ST_IDLE;
            bit_cnt_ff <= 4'h0;
            shift_ff <= 8'h00;
            cmd_ff <= 8'h00;
            byte_idx_ff <= 2'h0;
            rd_ff <= 1'b0;
            drive_ff <= 1'b0;
            tx_ff <= 8'h00;
            nack_ff <= 1'b0;
        end else begin
            state_ff <= nxt_state;
            if (start_c) begin
                bit_cnt_ff <= 4'h0;
                byte_idx_ff <= 2'h0;
                drive_ff <= 1'b0;
            end else if (scl_rise && (state_ff == ST_ADDR || state_ff == ST_RX)) begin
                shift_ff <= rx_byte;
                bit_cnt_ff <= bit_cnt_ff + 4'h1;
            end else if (scl_rise && state_ff == ST_TX) begin
                bit_cnt_ff <= bit_cnt_ff + 4'h1;
            end else if (scl_rise && state_ff == ST_TXACK) begin
                nack_ff <= sda_s;
            end
            if (scl_fall) begin
                case (nxt_state)
                    ST_ACK: begin
                        drive_ff <= 1'b1;
                        bit_cnt_ff <= 4'h0;
                        if (state_ff == ST_ADDR) begin
                            rd_ff <= shift_ff[0];
                        end else if (byte_idx_ff == 2'h0) begin
                            cmd_ff <= shift_ff;
                            byte_idx_ff <= 2'h1;
                        end else begin
                            byte_idx_ff <= byte_idx_ff + 2'h1;
                        end
                    end
                    ST_TX: begin
                        tx_ff <= (state_ff == ST_ACK) ?
                            read_mux(cmd_ff, 2'h0, sum_byte, sum_high) : {tx_ff[6:0], 1'b0};
                        if (state_ff == ST_ACK || state_ff == ST_TXACK) begin
                            bit_cnt_ff <= 4'h0;
                            if (state_ff == ST_TXACK) begin
                                tx_ff <= read_mux(cmd_ff, 2'h1, sum_byte, sum_high);
                            end
                        end
                        drive_ff <= 1'b1;
                    end
                    default: drive_ff <= 1'b0;
                endcase
            end
            if (stop_c) begin
                drive_ff <= 1'b0;
            end
        end
    end

    // The pin is open-drain: only a low is ever driven.
    wire tx_bit = (state_ff == ST_TX) ? tx_ff[7] : 1'b0;
    assign sda_o = 1'b0;
    assign sda_oe_o = drive_ff & ~tx_bit;
endmodule
`default_nettype wire

// [logic/pss_summary.v]
// Purpose: Combinational builder of the summary byte and summary word.
// Assumes: Source status bytes already hold their latched flags.
// Notes: No state here, so every read sees the sources of that moment.
`timescale 1ns/1ps
`default_nettype none
`include "pss_consts.vh"
module pss_summary (
    input wire [7:0] vout_status_i,
    input wire [7:0] iout_status_i,
    input wire [7:0] input_status_i,
    input wire [7:0] temp_status_i,
    input wire [7:0] cml_status_i,
    input wire [7:0] mfr_status_i,
    input wire converter_en_i,
    input wire loop_slave_i,
    input wire power_not_good_i,
    output reg [7:0] summary_byte_o,
    output reg [7:0] summary_high_o
);
    reg [7:0] vout_eff;
    always @* begin
        vout_eff = loop_slave_i ? 8'h00 : vout_status_i;
        summary_byte_o = 8'h00;
        summary_high_o = 8'h00;
        summary_byte_o[`PSS_SB_OFF] = ~converter_en_i;
        summary_byte_o[`PSS_SB_OVF] = vout_eff[`PSS_VOUT_OVF];
        summary_byte_o[`PSS_SB_OCF] = iout_status_i[`PSS_IOUT_OCF];
        summary_byte_o[`PSS_SB_TEMP] = |temp_status_i[7:6];
        summary_byte_o[`PSS_SB_CML] = |cml_status_i;
        summary_byte_o[`PSS_SB_OTHER] = vout_eff[`PSS_VOUT_UVF] |
            iout_status_i[`PSS_IOUT_OCW] | vout_eff[`PSS_VOUT_OVW] |
            vout_eff[`PSS_VOUT_UVW] | vout_eff[`PSS_VOUT_TON] |
            input_status_i[`PSS_INPUT_LOWVIN] | vout_eff[`PSS_VOUT_RANGE] |
            mfr_status_i[`PSS_MFR_BG] | mfr_status_i[`PSS_MFR_PWR];
        summary_high_o[`PSS_HB_VOUT] = |vout_eff[7:2];
        summary_high_o[`PSS_HB_IOUT] = iout_status_i[`PSS_IOUT_OCF] |
            iout_status_i[`PSS_IOUT_OCW];
        summary_high_o[`PSS_HB_INPUT] = |input_status_i;
        summary_high_o[`PSS_HB_VENDOR] = mfr_status_i[`PSS_MFR_BG] |
            mfr_status_i[`PSS_MFR_PWR];
        summary_high_o[`PSS_HB_PNG] = power_not_good_i;
    end
endmodule
`default_nettype wire

// [logic/pss_sync2.v]
// Purpose: Two-flop synchroniser for a level from outside the clock domain.
// Assumes: Input changes slowly against clock_i.
// Notes: The first stage is read by the second stage only.
`timescale 1ns/1ps
`default_nettype none
module pss_sync2 #(
    parameter WIDTH = 1
) (
    input wire clock_i,
    input wire rst_b_i,
    input wire [WIDTH-1:0] async_i,
    input wire [WIDTH-1:0] reset_val_i,
    output wire [WIDTH-1:0] sync_o
);
    reg [WIDTH-1:0] meta_ff;
    reg [WIDTH-1:0] sync_ff;
    always @(posedge clock_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            meta_ff <= {WIDTH{1'b1}};
            sync_ff <= {WIDTH{1'b1}};
        end else begin
            meta_ff <= async_i;
            sync_ff <= meta_ff;
        end
    end
    assign sync_o = sync_ff;
endmodule
`default_nettype wire

// [shared/pss_consts.vh]
// Purpose: Constants for the status-summary block.
// Assumes: Byte-wide command codes on the management bus.
// Notes: Bit positions index the summary byte, the summary word's high byte and the source status bytes.
`ifndef PSS_CONSTS_VH
`define PSS_CONSTS_VH
`define PSS_CMD_SUMMARY_BYTE 8'h78
`define PSS_CMD_SUMMARY_WORD 8'h79
`define PSS_CMD_MASK_WR 8'h1B
`define PSS_CMD_STATUS_VOUT 8'h7A
`define PSS_CMD_STATUS_IOUT 8'h7B
`define PSS_CMD_STATUS_INPUT 8'h7C
`define PSS_CMD_STATUS_TEMP 8'h7D
`define PSS_CMD_STATUS_CML 8'h7E
`define PSS_CMD_STATUS_MFR 8'h80
`define PSS_INPUT_RESET 8'h08
`define PSS_SB_OFF 6
`define PSS_SB_OVF 5
`define PSS_SB_OCF 4
`define PSS_SB_TEMP 2
`define PSS_SB_CML 1
`define PSS_SB_OTHER 0
`define PSS_HB_VOUT 7
`define PSS_HB_IOUT 6
`define PSS_HB_INPUT 5
`define PSS_HB_VENDOR 4
`define PSS_HB_PNG 3
`define PSS_VOUT_OVF 7
`define PSS_VOUT_OVW 6
`define PSS_VOUT_UVW 5
`define PSS_VOUT_UVF 4
`define PSS_VOUT_RANGE 3
`define PSS_VOUT_TON 2
`define PSS_IOUT_OCF 7
`define PSS_IOUT_OCW 5
`define PSS_INPUT_LOWVIN 3
`define PSS_MFR_BG 7
`define PSS_MFR_PWR 6
`define PSS_PNG_MASK_RESET 1'b1
`define PSS_ADDR_RESET 7'h40
`endif

// [test/pss_host_model.sv]
// Purpose: Management-bus host that reads and writes the status block.
// Assumes: One bus bit per 8 clocks, a bus clock period of 800 ns.
// Notes: SDA is open drain; the host only pulls low or lets go.
`timescale 1ns/1ps
`default_nettype none
`include "pss_consts.vh"
module pss_host_model #(
    parameter logic [6:0] ADDR = `PSS_ADDR_RESET
) (
    input wire logic clock_i,
    input wire logic sda_i,
    output logic scl_o,
    output logic sda_oe_o
);
    logic [7:0] nak_cnt = 8'h00;
    initial begin
        scl_o = 1'b1;
        sda_oe_o = 1'b0;
    end
    task automatic tick(input int n);
        repeat (n) @(posedge clock_i);
    endtask
    // Data moves mid-low, so it never changes while SCL is high.
    task automatic xbit(input logic v, output logic r);
        tick(2);
        sda_oe_o <= !v;
        tick(2);
        r = sda_i;
        scl_o <= 1'b1;
        tick(4);
        scl_o <= 1'b0;
    endtask
    task automatic start();
        tick(2);
        sda_oe_o <= 1'b0;
        tick(2);
        scl_o <= 1'b1;
        tick(2);
        sda_oe_o <= 1'b1;
        tick(2);
        scl_o <= 1'b0;
    endtask
    task automatic stop();
        tick(2);
        sda_oe_o <= 1'b1;
        tick(2);
        scl_o <= 1'b1;
        tick(2);
        sda_oe_o <= 1'b0;
        tick(4);
    endtask
    task automatic xbyte(input logic [7:0] d, input logic ack, output logic [7:0] q,
                         output logic a);
        for (int i = 7; i >= 0; i--) begin
            xbit(d[i], q[i]);
        end
        xbit(ack, a);
    endtask
    task automatic addr(input logic rd);
        logic [7:0] q;
        logic a;
        xbyte({ADDR, rd}, 1'b1, q, a);
        nak_cnt <= nak_cnt + {7'h00, a};
    endtask
    // A foreign address must be left unanswered, so the line stays released.
    task automatic probe(input logic [6:0] a7, output logic a);
        logic [7:0] q;
        start();
        xbyte({a7, 1'b0}, 1'b1, q, a);
        stop();
    endtask
    task automatic write_cmd(input logic [7:0] c, input logic [7:0] d);
        logic [7:0] q;
        logic a;
        start();
        addr(1'b0);
        xbyte(c, 1'b1, q, a);
        xbyte(d, 1'b1, q, a);
        stop();
    endtask
    task automatic read_cmd(input logic [7:0] c, output logic [15:0] w);
        logic [7:0] q;
        logic a;
        start();
        addr(1'b0);
        xbyte(c, 1'b1, q, a);
        start();
        addr(1'b1);
        xbyte(8'hFF, 1'b0, w[7:0], a);
        xbyte(8'hFF, 1'b1, w[15:8], a);
        stop();
    endtask
endmodule
`default_nettype wire

// [test/pss_status_summary_sva.sv]
// Purpose: Port checks of alert timing and bus drive of the status block.
// Assumes: Source events are pulses; the alert follows within a few clocks.
// Notes: Summary contents are judged over the bus by the bench.
`timescale 1ns/1ps
`default_nettype none
module pss_status_summary_sva (
    input wire logic clock_i,
    input wire logic rst_b_i,
    input wire logic scl_i,
    input wire logic sda_oe_o,
    input wire logic [7:0] vout_event_i,
    input wire logic [7:0] iout_event_i,
    input wire logic [7:0] temp_event_i,
    input wire logic [7:0] cml_event_i,
    input wire logic [7:0] mfr_event_i,
    input wire logic vin_above_on_i,
    input wire logic vin_below_off_i,
    input wire logic loop_slave_i,
    input wire logic [7:0] nv_mask_vout_i,
    input wire logic [7:0] nv_mask_iout_i,
    input wire logic [7:0] nv_mask_input_i,
    input wire logic [7:0] nv_mask_temp_i,
    input wire logic [7:0] nv_mask_cml_i,
    input wire logic [7:0] nv_mask_mfr_i,
    input wire logic smbalert_b_o
);
    default clocking cb @(posedge clock_i);
    endclocking
    default disable iff (!rst_b_i);
    // A low supply may only alert once it has been seen above turn-on.
    logic seen_on_ff;
    always_ff @(posedge clock_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            seen_on_ff <= 1'b0;
        end else if (vin_above_on_i) begin
            seen_on_ff <= 1'b1;
        end
    end
    sequence alert_soon;
        ##[1:8] !smbalert_b_o;
    endsequence
    AST_QUIET_AFTER_RESET: assert property ($rose(rst_b_i) |-> smbalert_b_o [*3])
        else $error("alert raised right after reset");
    AST_OV_ALERT: assert property (vout_event_i[7] && !nv_mask_vout_i[7]
        && !loop_slave_i |-> alert_soon) else $error("overvoltage did not alert");
    AST_OC_ALERT: assert property (iout_event_i[7] && !nv_mask_iout_i[7]
        |-> alert_soon) else $error("overcurrent did not alert");
    AST_TEMP_ALERT: assert property (|(temp_event_i & ~nv_mask_temp_i & 8'hC0)
        |-> alert_soon) else $error("temperature did not alert");
    AST_COMM_ALERT: assert property (|(cml_event_i & ~nv_mask_cml_i)
        |-> alert_soon) else $error("comm fault did not alert");
    AST_VENDOR_ALERT: assert property (|(mfr_event_i & ~nv_mask_mfr_i & 8'hC0)
        |-> alert_soon) else $error("vendor fault did not alert");
    AST_LOWVIN_ALERT: assert property (vin_below_off_i && seen_on_ff
        && !nv_mask_input_i[3] |-> alert_soon) else $error("low input did not alert");
    AST_BUS_DRIVE: assert property ($changed(sda_oe_o) |-> !scl_i)
        else $error("data drive moved while clock high");
endmodule
bind pss_status_summary pss_status_summary_sva u_sva (
    .clock_i(clock_i), .rst_b_i(rst_b_i), .scl_i(scl_i), .sda_oe_o(sda_oe_o),
    .vout_event_i(vout_event_i), .iout_event_i(iout_event_i),
    .temp_event_i(temp_event_i), .cml_event_i(cml_event_i), .mfr_event_i(mfr_event_i),
    .vin_above_on_i(vin_above_on_i), .vin_below_off_i(vin_below_off_i),
    .loop_slave_i(loop_slave_i), .nv_mask_vout_i(nv_mask_vout_i),
    .nv_mask_iout_i(nv_mask_iout_i), .nv_mask_input_i(nv_mask_input_i),
    .nv_mask_temp_i(nv_mask_temp_i), .nv_mask_cml_i(nv_mask_cml_i),
    .nv_mask_mfr_i(nv_mask_mfr_i), .smbalert_b_o(smbalert_b_o));
`default_nettype wire

// [test/tb.sv]
// Purpose: Self-checking bench of the status summary block.
// Assumes: Detailed flags are cleared by write-one to their commands.
// Notes: Every expected value is built from the bit map, not read back.
`timescale 1ns/1ps
`default_nettype none
`include "pss_consts.vh"
module tb;
    logic clock_i = 1'b0;
    logic rst_b_i = 1'b0;
    logic [7:0] ev [5] = '{default: 8'h00};
    logic [7:0] msk [6] = '{default: 8'h00};
    logic vin_on = 1'b0;
    logic vin_off = 1'b0;
    logic conv_en = 1'b0;
    logic slave = 1'b0;
    logic png = 1'b0;
    wire scl, sda, sda_o, sda_oe, host_oe, alert_b;
    int mismatches = 0;
    int compares = 0;
    logic [15:0] w;
    logic [7:0] clr [5] = '{8'h7A, 8'h7B, 8'h7D, 8'h7E, 8'h80};
    // Source, bit, expected summary byte, expected high byte.
    logic [23:0] tab [13] = '{24'h072080, 24'h060180, 24'h050180, 24'h040180,
        24'h030180, 24'h020180, 24'h171040, 24'h150140, 24'h270400, 24'h260400,
        24'h370200, 24'h470110, 24'h460110};
    // The line is pulled up unless some party pulls it low.
    assign sda = (sda_oe ? sda_o : 1'b1) & !host_oe;
    pss_status_summary uut (.clock_i(clock_i), .rst_b_i(rst_b_i), .scl_i(scl),
        .sda_i(sda), .sda_o(sda_o), .sda_oe_o(sda_oe), .vout_event_i(ev[0]),
        .iout_event_i(ev[1]), .temp_event_i(ev[2]), .cml_event_i(ev[3]),
        .mfr_event_i(ev[4]), .vin_above_on_i(vin_on), .vin_below_off_i(vin_off),
        .converter_en_i(conv_en), .loop_slave_i(slave), .power_not_good_i(png),
        .nv_mask_vout_i(msk[0]), .nv_mask_iout_i(msk[1]), .nv_mask_input_i(msk[2]),
        .nv_mask_temp_i(msk[3]), .nv_mask_cml_i(msk[4]), .nv_mask_mfr_i(msk[5]),
        .smbalert_b_o(alert_b));
    pss_host_model host (.clock_i(clock_i), .sda_i(sda), .scl_o(scl), .sda_oe_o(host_oe));
    initial begin
        forever #50 clock_i = ~clock_i;
    end
    task automatic tick(input int n);
        repeat (n) @(posedge clock_i);
    endtask
    task automatic cmp(input string n, input logic [15:0] got, input logic [15:0] exp);
        compares++;
        if (got !== exp) begin
            mismatches++;
            $display("unexpected %s expected %h seen %h", n, exp, got);
        end
    endtask
    task automatic cmp_a(input logic e);
        cmp("alert", {15'h0000, alert_b}, {15'h0000, e});
    endtask
    task automatic rdw(input logic [15:0] e);
        host.read_cmd(`PSS_CMD_SUMMARY_WORD, w);
        cmp("word", w, e);
    endtask
    task pulse(input int s, input int b);
        ev[s][b] <= 1'b1;
        tick(1);
        ev[s][b] <= 1'b0;
        tick(4);
    endtask
    task automatic end_sim();
        $display("compares %0d mismatches %0d", compares, mismatches);
        if (mismatches == 0 && compares > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    task automatic t_power_up();
        logic a;
        host.read_cmd(`PSS_CMD_SUMMARY_BYTE, w);
        cmp("byte", {8'h00, w[7:0]}, 16'h0041); // Power-up byte.
        rdw(16'h2041); // Power-up word.
        cmp_a(1'b1); // Quiet alert.
        host.probe(`PSS_ADDR_RESET ^ 7'h01, a);
        cmp("foreign address ack", {15'h0000, a}, 16'h0001); // No answer.
    endtask
    task automatic t_lowvin();
        vin_on <= 1'b1;
        conv_en <= 1'b1;
        tick(10);
        host.write_cmd(8'h7C, 8'h08);
        rdw(16'h0000); // Enabled and cleared.
        vin_on <= 1'b0;
        vin_off <= 1'b1;
        tick(10);
        vin_off <= 1'b0;
        tick(4);
        rdw(16'h2001); // Latched low input.
        cmp_a(1'b0); // Alert raised.
        msk[2] <= 8'h08;
        tick(8);
        cmp_a(1'b1); // Stored mask.
        msk[2] <= 8'h00;
        vin_on <= 1'b1;
        tick(8);
        host.write_cmd(8'h7C, 8'h08);
        rdw(16'h0000); // Cleared at source.
        cmp_a(1'b1); // Alert gone.
    endtask
    task automatic t_sources();
        logic [23:0] e;
        for (int i = 0; i < 13; i++) begin
            e = tab[i];
            pulse(int'(e[23:20]), int'(e[19:16]));
            rdw({e[7:0], e[15:8]});
            host.write_cmd(clr[e[22:20]], 8'h01 << e[19:16]);
            rdw(16'h0000); // Source cleared.
        end
    endtask
    task automatic t_ov_write();
        pulse(0, 7);
        host.write_cmd(`PSS_CMD_SUMMARY_BYTE, 8'hFF);
        host.write_cmd(`PSS_CMD_SUMMARY_WORD, 8'hFF);
        rdw(16'h8020); // Writes ignored.
        cmp_a(1'b0); // Source unmasked.
        msk[0] <= 8'h80;
        tick(8);
        cmp_a(1'b1); // Source masked.
        msk[0] <= 8'h00;
        host.write_cmd(8'h7A, 8'h80);
        slave <= 1'b1;
        pulse(0, 7);
        rdw(16'h0000); // Loop slave forced.
        host.write_cmd(8'h7A, 8'hFF);
        slave <= 1'b0;
    endtask
    task automatic t_png();
        png <= 1'b1;
        tick(8);
        rdw(16'h0800); // Live not-good.
        cmp_a(1'b1); // Default mask.
        rst_b_i <= 1'b0;
        tick(20);
        rst_b_i <= 1'b1;
        tick(4);
        host.write_cmd(`PSS_CMD_MASK_WR, 8'h00);
        tick(8);
        cmp_a(1'b1); // No good yet.
        png <= 1'b0;
        tick(8);
        png <= 1'b1;
        tick(8);
        cmp_a(1'b0); // After first good.
    endtask
    initial begin
        tick(20);
        rst_b_i <= 1'b1;
        tick(4);
        t_power_up();
        t_lowvin();
        t_sources();
        t_ov_write();
        t_png();
        cmp("naks", {8'h00, host.nak_cnt}, 16'h0000); // Address acked.
        end_sim();
    end
    // A hung transfer must still reach the verdict.
    initial begin
        tick(90000);
        mismatches++;
        end_sim();
    end
endmodule
`default_nettype wire
